//--- inc/sdram_cmd_map.svh
`ifndef SDRAM_CMD_MAP_SVH
`define SDRAM_CMD_MAP_SVH

// apb register byte offsets
`define MAP_MODE_OFFSET       8'h00
`define MAP_STATUS_OFFSET     8'h04
`define MAP_REFRESH_OFFSET    8'h08
`define MAP_CONTROL_OFFSET    8'h0C
`define MAP_ROW_VIEW_OFFSET   8'h10

// control register
`define CTRL_WIDTH            3
`define CTRL_RESET            3'h1
`define CTRL_TIMER_EN_BIT     0
`define CTRL_VIEW_LSB         1

// status register fields
`define STATUS_BANK_LSB       0
`define STATUS_BURST_BIT      4
`define STATUS_SUSPEND_BIT    5
`define STATUS_DOWN_BIT       6
`define STATUS_SELF_BIT       7
`define STATUS_MODE_BIT       8

// mode register fields
`define MODE_WIDTH            12
`define MODE_RESET            12'h000
`define MODE_BL_LSB           0
`define MODE_WRAP_BIT         3
`define MODE_CL_LSB           4
`define BL_ONE                3'h0
`define BL_TWO                3'h1
`define BL_FOUR               3'h2
`define BL_EIGHT              3'h3
`define BL_FULL_PAGE          3'h7
`define CL_THREE              3'h3

// address pin roles
`define ADDR_AUTOCLOSE_BIT    10

// refresh timing
`define REFRESH_PERIOD_MS     64
`define REFRESH_ROWS          4096
`define CLOCK_PERIOD_NS       40
`define REFRESH_INTERVAL_CYCLES ((`REFRESH_PERIOD_MS * 1000000) / (`REFRESH_ROWS * `CLOCK_PERIOD_NS))
`define REFRESH_TIMER_WIDTH   9
`define REFRESH_COUNT_WIDTH   14

`endif

//--- inc/sdram_cmd_pkg.sv
package sdram_cmd_pkg;

    typedef enum logic [2:0] {
        CMD_DESELECT,
        CMD_IDLE,
        CMD_ROW_OPEN,
        CMD_READ,
        CMD_WRITE,
        CMD_CLOSE,
        CMD_MODE_LOAD,
        CMD_REFRESH
    } cmd_type;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_DOWN,
        PWR_SELF
    } power_state_type;

endpackage : sdram_cmd_pkg

//--- logic/burst_column_gen.sv
`timescale 1ns/1ps

module burst_column_gen #(
    parameter int COL_W = 10
) (
    // burst origin
    input  wire logic [COL_W-1:0] start_col,
    input  wire logic [COL_W-1:0] beat,
    input  wire logic [COL_W-1:0] block_mask,
    input  wire logic             interleave,
    // generated column
    output logic      [COL_W-1:0] column
);

    wire [COL_W-1:0] offset  = start_col & block_mask;
    wire [COL_W-1:0] seq_off = (offset + beat) & block_mask;
    wire [COL_W-1:0] int_off = (offset ^ beat) & block_mask;

    // the block boundary never moves: only the low bits wrap
    assign column = (start_col & ~block_mask) | (interleave ? int_off : seq_off);

endmodule : burst_column_gen

//--- logic/sdram_command_interface.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "sdram_cmd_map.svh"

module sdram_command_interface #(
    parameter int ORG_WIDTH    = 16,
    parameter int MEM_COL_BITS = 4
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // command pins
    input  wire logic        clock_gate,
    input  wire logic        select_n,
    input  wire logic        row_strobe_n,
    input  wire logic        column_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [11:0] address,
    input  wire logic [1:0]  bank_select_pair,
    // data pins
    input  wire logic        low_byte_mask,
    input  wire logic        high_byte_mask,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic      [1:0]  dq_oe
);

    localparam int COL_W     = 10;
    localparam int MEM_DEPTH = 4 << MEM_COL_BITS;
    localparam logic [COL_W-1:0] PAGE_MASK = (ORG_WIDTH == 4) ? 10'h3FF :
                                             (ORG_WIDTH == 8) ? 10'h1FF : 10'h0FF;
    localparam logic [`REFRESH_TIMER_WIDTH-1:0] TIMER_LAST =
        `REFRESH_TIMER_WIDTH'(`REFRESH_INTERVAL_CYCLES - 1);
    localparam logic ORG16   = (ORG_WIDTH == 16);

    function automatic sdram_cmd_pkg::cmd_type decode_cmd(input logic [3:0] pins);
        case (pins)
            4'b0011: decode_cmd = sdram_cmd_pkg::CMD_ROW_OPEN;
            4'b0101: decode_cmd = sdram_cmd_pkg::CMD_READ;
            4'b0100: decode_cmd = sdram_cmd_pkg::CMD_WRITE;
            4'b0010: decode_cmd = sdram_cmd_pkg::CMD_CLOSE;
            4'b0000: decode_cmd = sdram_cmd_pkg::CMD_MODE_LOAD;
            4'b0001: decode_cmd = sdram_cmd_pkg::CMD_REFRESH;
            4'b0111: decode_cmd = sdram_cmd_pkg::CMD_IDLE;
            default: decode_cmd = sdram_cmd_pkg::CMD_DESELECT;
        endcase
    endfunction : decode_cmd

    // reserved length codes fall back to a single beat
    function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] code);
        case (code)
            `BL_TWO:       burst_mask = 10'h001;
            `BL_FOUR:      burst_mask = 10'h003;
            `BL_EIGHT:     burst_mask = 10'h007;
            `BL_FULL_PAGE: burst_mask = PAGE_MASK;
            default:       burst_mask = 10'h000;
        endcase
    endfunction : burst_mask

    function automatic logic [3:0] bank_bit(input logic [1:0] bank);
        bank_bit = 4'h1 << bank;
    endfunction : bank_bit

    // ---------------- state ----------------
    sdram_cmd_pkg::power_state_type power_state_reg;
    sdram_cmd_pkg::power_state_type power_state_next;
    logic                            gate_prev_reg;
    logic [`MODE_WIDTH-1:0]          mode_reg;
    logic                            mode_loaded_reg;
    logic [3:0]                      bank_open_reg;
    logic [11:0]                     row_reg [0:3];
    logic                            burst_active_reg;
    logic                            burst_write_reg;
    logic                            burst_autoclose_reg;
    logic                            burst_full_reg;
    logic                            burst_interleave_reg;
    logic [1:0]                      burst_bank_reg;
    logic [COL_W-1:0]                burst_start_reg;
    logic [COL_W-1:0]                burst_mask_reg;
    logic [COL_W-1:0]                beat_reg;
    logic [`REFRESH_COUNT_WIDTH-1:0] refresh_count_reg;
    logic [`REFRESH_TIMER_WIDTH-1:0] refresh_timer_reg;
    logic [`CTRL_WIDTH-1:0]          ctrl_reg;
    logic [31:0]                     prdata_reg;
    logic [15:0]                     mem [0:MEM_DEPTH-1];
    logic [15:0]                     rd_data_reg [0:2];
    logic [2:0]                      rd_valid_reg;
    logic [1:0]                      mask_d1_reg;
    logic [1:0]                      mask_d2_reg;

    // ---------------- command decode ----------------
    sdram_cmd_pkg::cmd_type cmd;
    assign cmd = decode_cmd({select_n, row_strobe_n, column_strobe_n, write_strobe_n});

    // commands count only while the internal clock ran on the previous edge
    wire running    = power_state_reg == sdram_cmd_pkg::PWR_RUN;
    wire cmd_live   = running & gate_prev_reg;
    wire idle_like  = (cmd == sdram_cmd_pkg::CMD_IDLE) | (cmd == sdram_cmd_pkg::CMD_DESELECT);
    wire gate_fall  = gate_prev_reg & ~clock_gate;
    wire gate_rise  = ~gate_prev_reg & clock_gate;
    wire is_read    = cmd_live & (cmd == sdram_cmd_pkg::CMD_READ);
    wire is_write   = cmd_live & (cmd == sdram_cmd_pkg::CMD_WRITE);
    wire new_rw     = is_read | is_write;
    wire is_open    = cmd_live & (cmd == sdram_cmd_pkg::CMD_ROW_OPEN);
    wire is_close   = cmd_live & (cmd == sdram_cmd_pkg::CMD_CLOSE);
    wire is_mode    = cmd_live & (cmd == sdram_cmd_pkg::CMD_MODE_LOAD);
    wire is_refresh = cmd_live & (cmd == sdram_cmd_pkg::CMD_REFRESH);
    wire auto_ref   = is_refresh & clock_gate;
    wire self_enter = is_refresh & ~clock_gate;
    wire autoclose  = address[`ADDR_AUTOCLOSE_BIT];

    // ---------------- burst setup ----------------
    wire [2:0]       bl_code    = mode_reg[`MODE_BL_LSB +: 3];
    wire             cmd_full   = bl_code == `BL_FULL_PAGE;
    wire [COL_W-1:0] cmd_mask   = burst_mask(bl_code);
    wire             cmd_intlv  = mode_reg[`MODE_WRAP_BIT] & ~cmd_full;
    wire [COL_W-1:0] col_in     = address[COL_W-1:0] & PAGE_MASK;
    wire             cmd_single = cmd_mask == 10'h000;

    // a suspended burst holds its place until the gate returns
    wire burst_step = running & gate_prev_reg & burst_active_reg & ~new_rw;
    wire beat_last  = ~burst_full_reg & (beat_reg == burst_mask_reg);
    // a close aimed at the bursting bank ends the burst, also a full page one
    wire burst_kill = is_close & (autoclose | (bank_select_pair == burst_bank_reg));

    // ---------------- column generation ----------------
    wire [COL_W-1:0] gen_start = new_rw ? col_in : burst_start_reg;
    wire [COL_W-1:0] gen_beat  = new_rw ? 10'h000 : beat_reg;
    wire [COL_W-1:0] gen_mask  = new_rw ? cmd_mask : burst_mask_reg;
    wire             gen_intlv = new_rw ? cmd_intlv : burst_interleave_reg;
    wire [1:0]       gen_bank  = new_rw ? bank_select_pair : burst_bank_reg;
    wire [COL_W-1:0] gen_col;

    burst_column_gen #(
        .COL_W      (COL_W)
    ) u_column (
        .start_col  (gen_start),
        .beat       (gen_beat),
        .block_mask (gen_mask),
        .interleave (gen_intlv),
        .column     (gen_col)
    );

    // the data store keeps only a window of columns per bank; rows alias
    wire [MEM_COL_BITS+1:0] mem_idx  = {gen_bank, gen_col[MEM_COL_BITS-1:0]};
    wire                    do_write = is_write | (burst_step & burst_write_reg);
    wire                    do_read  = is_read | (burst_step & ~burst_write_reg);
    wire                    lo_mask  = low_byte_mask;
    wire                    hi_mask  = ORG16 ? high_byte_mask : low_byte_mask;

    // ---------------- bank bookkeeping ----------------
    wire [3:0] close_cmd   = is_close ? (autoclose ? 4'hF : bank_bit(bank_select_pair)) : 4'h0;
    wire [3:0] close_now   = (new_rw & autoclose & cmd_single) ? bank_bit(bank_select_pair) : 4'h0;
    wire [3:0] close_end   = (burst_step & beat_last & burst_autoclose_reg) ? bank_bit(burst_bank_reg) : 4'h0;
    wire [3:0] open_vec    = is_open ? bank_bit(bank_select_pair) : 4'h0;
    wire [3:0] bank_next   = (bank_open_reg & ~(close_cmd | close_now | close_end)) | open_vec;

    // ---------------- power state ----------------
    always_comb begin
        power_state_next = power_state_reg;
        case (power_state_reg)
            sdram_cmd_pkg::PWR_RUN: begin
                if (self_enter) begin
                    power_state_next = sdram_cmd_pkg::PWR_SELF;
                end else if (gate_fall & idle_like & ~burst_active_reg) begin
                    power_state_next = sdram_cmd_pkg::PWR_DOWN;
                end
            end
            sdram_cmd_pkg::PWR_DOWN: begin
                if (gate_rise & idle_like) begin
                    power_state_next = sdram_cmd_pkg::PWR_RUN;
                end
            end
            sdram_cmd_pkg::PWR_SELF: begin
                if (gate_rise & idle_like) begin
                    power_state_next = sdram_cmd_pkg::PWR_RUN;
                end
            end
            default: power_state_next = sdram_cmd_pkg::PWR_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_state_reg <= sdram_cmd_pkg::PWR_RUN;
            gate_prev_reg   <= 1'b1;
        end else begin
            power_state_reg <= power_state_next;
            gate_prev_reg   <= clock_gate;
        end
    end

    // ---------------- mode and banks ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg        <= `MODE_RESET;
            mode_loaded_reg <= 1'b0;
            bank_open_reg   <= 4'h0;
        end else begin
            if (is_mode) begin
                mode_reg        <= address;
                mode_loaded_reg <= 1'b1;
            end
            bank_open_reg <= bank_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int b = 0; b < 4; b++) begin
                row_reg[b] <= 12'h000;
            end
        end else if (is_open) begin
            row_reg[bank_select_pair] <= address;
        end
    end

    // ---------------- burst engine ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_active_reg     <= 1'b0;
            burst_write_reg      <= 1'b0;
            burst_autoclose_reg  <= 1'b0;
            burst_full_reg       <= 1'b0;
            burst_interleave_reg <= 1'b0;
            burst_bank_reg       <= 2'h0;
            burst_start_reg      <= 10'h000;
            burst_mask_reg       <= 10'h000;
            beat_reg             <= 10'h000;
        end else if (new_rw) begin
            // a new access overrides whatever burst was running
            burst_active_reg     <= ~cmd_single;
            burst_write_reg      <= is_write;
            burst_autoclose_reg  <= autoclose;
            burst_full_reg       <= cmd_full;
            burst_interleave_reg <= cmd_intlv;
            burst_bank_reg       <= bank_select_pair;
            burst_start_reg      <= col_in;
            burst_mask_reg       <= cmd_mask;
            beat_reg             <= 10'h001;
        end else if (burst_kill) begin
            burst_active_reg <= 1'b0;
        end else if (burst_step) begin
            if (beat_last) begin
                burst_active_reg <= 1'b0;
            end
            beat_reg <= (beat_reg + 10'h001) & burst_mask_reg;
        end
    end

    // ---------------- data store ----------------
    always_ff @(posedge pclk) begin
        if (do_write) begin
            if (!lo_mask) begin
                mem[mem_idx][7:0] <= dq_in[7:0];
            end
            if (!hi_mask) begin
                mem[mem_idx][15:8] <= dq_in[15:8];
            end
        end
    end

    // read data and a two-stage mask pipe share one enable; a stopped clock freezes both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int s = 0; s < 3; s++) begin
                rd_data_reg[s] <= 16'h0000;
            end
            rd_valid_reg <= 3'h0;
            mask_d1_reg  <= 2'h0;
            mask_d2_reg  <= 2'h0;
        end else if (gate_prev_reg) begin
            rd_data_reg[0] <= mem[mem_idx];
            rd_data_reg[1] <= rd_data_reg[0];
            rd_data_reg[2] <= rd_data_reg[1];
            rd_valid_reg   <= {rd_valid_reg[1:0], do_read};
            mask_d1_reg    <= {hi_mask, lo_mask};
            mask_d2_reg    <= mask_d1_reg;
        end
    end

    wire cl_three  = mode_reg[`MODE_CL_LSB +: 3] == `CL_THREE;
    wire out_valid = cl_three ? rd_valid_reg[2] : rd_valid_reg[1];

    assign dq_out   = cl_three ? rd_data_reg[2] : rd_data_reg[1];
    assign dq_oe[0] = out_valid & ~mask_d2_reg[0];
    assign dq_oe[1] = out_valid & ~mask_d2_reg[1];

    // ---------------- internal refresh ----------------
    wire timer_on   = (power_state_reg == sdram_cmd_pkg::PWR_SELF) & ctrl_reg[`CTRL_TIMER_EN_BIT];
    wire timer_hit  = timer_on & (refresh_timer_reg == TIMER_LAST);
    wire refresh_go = auto_ref | timer_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refresh_timer_reg <= '0;
            refresh_count_reg <= '0;
        end else begin
            refresh_timer_reg <= (timer_on & ~timer_hit) ? refresh_timer_reg + 1'b1 : '0;
            if (refresh_go) begin
                // low bits step the bank, upper bits the row
                refresh_count_reg <= refresh_count_reg + 1'b1;
            end
        end
    end

    // ---------------- apb slave ----------------
    wire sel_mode    = paddr == `MAP_MODE_OFFSET;
    wire sel_status  = paddr == `MAP_STATUS_OFFSET;
    wire sel_refresh = paddr == `MAP_REFRESH_OFFSET;
    wire sel_ctrl    = paddr == `MAP_CONTROL_OFFSET;
    wire sel_row     = paddr == `MAP_ROW_VIEW_OFFSET;
    wire mapped      = sel_mode | sel_status | sel_refresh | sel_ctrl | sel_row;
    wire apb_setup   = psel & ~penable;
    wire apb_access  = psel & penable;
    wire ctrl_write  = apb_access & pwrite & sel_ctrl;

    logic [31:0] status_word;
    logic [31:0] read_mux;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`STATUS_BANK_LSB +: 4] = bank_open_reg;
        status_word[`STATUS_BURST_BIT]     = burst_active_reg;
        status_word[`STATUS_SUSPEND_BIT]   = burst_active_reg & ~gate_prev_reg;
        status_word[`STATUS_DOWN_BIT]      = power_state_reg == sdram_cmd_pkg::PWR_DOWN;
        status_word[`STATUS_SELF_BIT]      = power_state_reg == sdram_cmd_pkg::PWR_SELF;
        status_word[`STATUS_MODE_BIT]      = mode_loaded_reg;
    end

    assign read_mux = sel_mode    ? {20'h00000, mode_reg} :
                      sel_status  ? status_word :
                      sel_refresh ? {18'h00000, refresh_count_reg} :
                      sel_ctrl    ? {29'h00000000, ctrl_reg} :
                      sel_row     ? {20'h00000, row_reg[ctrl_reg[`CTRL_VIEW_LSB +: 2]]} :
                                    32'h0000_0000;

    // read data is captured in the setup cycle so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            ctrl_reg   <= `CTRL_RESET;
        end else begin
            if (apb_setup) begin
                prdata_reg <= read_mux;
            end
            if (ctrl_write) begin
                ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = apb_access & ~mapped;

endmodule : sdram_command_interface

//--- verification/mem_ctrl_model.sv
`timescale 1ns/1ps
module mem_ctrl_model (
    // clock
    input wire logic    pclk,
    // command and data pins
    output logic        clock_gate,
    output logic        select_n,
    output logic        row_strobe_n,
    output logic        column_strobe_n,
    output logic        write_strobe_n,
    output logic [11:0] address,
    output logic [1:0]  bank_select_pair,
    output logic        low_byte_mask,
    output logic        high_byte_mask,
    output logic [15:0] dq_in
);
    initial begin
        {select_n, row_strobe_n, column_strobe_n, write_strobe_n} = 4'hF;
        {clock_gate, high_byte_mask, low_byte_mask} = 3'h7;
        {address, bank_select_pair, dq_in} = '0;
    end
    task automatic drive(input logic [3:0] p, input logic [11:0] a, input logic [1:0] b, input logic g,
                         input logic [1:0] m, input logic [15:0] d);
        @(posedge pclk);
        {select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= p;
        address                         <= a;
        bank_select_pair                <= b;
        clock_gate                      <= g;
        {high_byte_mask, low_byte_mask} <= m;
        dq_in                           <= d;
    endtask : drive
    // don't-care lines toggle so a stale value never passes for a valid one
    task automatic idle_cmd(input logic g);
        drive(4'h7, ~address, ~bank_select_pair, g, 2'h0, ~dq_in);
    endtask : idle_cmd
    task automatic power_up(input logic [11:0] mode);
        repeat (5000) drive(4'h7, 12'h000, 2'h0, 1'b1, 2'h3, 16'h0000);
        drive(4'h2, 12'h400, 2'h0, 1'b1, 2'h3, 16'h0000);
        repeat (8) begin
            drive(4'h1, 12'h000, 2'h0, 1'b1, 2'h3, 16'h0000);
            idle_cmd(1'b1);
        end
        drive(4'h0, mode, 2'h0, 1'b1, 2'h0, 16'h0000);
        idle_cmd(1'b1);
    endtask : power_up
endmodule : mem_ctrl_model

//--- verification/sdram_command_checker.sv
`timescale 1ns/1ps
module sdram_command_checker (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins
    input wire logic        clock_gate,
    input wire logic        select_n,
    input wire logic        row_strobe_n,
    input wire logic        column_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [11:0] address,
    input wire logic        low_byte_mask,
    input wire logic        high_byte_mask,
    input wire logic [1:0]  dq_oe
);
    logic [3:0] pins;
    logic       read_go;
    logic       gate_reg;
    logic       lat3_reg;
    logic       lat3_next;
    logic       unmapped;
    assign pins      = {select_n, row_strobe_n, column_strobe_n, write_strobe_n};
    assign read_go   = pins == 4'h5 && gate_reg && clock_gate && !low_byte_mask && !high_byte_mask;
    // mode loads only count from a running clock
    assign lat3_next = (pins == 4'h0 && gate_reg) ? address[6:4] == 3'h3 : lat3_reg;
    assign unmapped  = psel && penable && paddr > 8'h10;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_reg <= 1'b1;
            lat3_reg <= 1'b0;
        end else begin
            gate_reg <= clock_gate;
            lat3_reg <= lat3_next;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence read_taken;
        read_go ##1 (!low_byte_mask && !high_byte_mask && clock_gate);
    endsequence
    a_ready_zero_wait: assert property (psel && penable |-> pready) else $error("access not answered");
    a_unmapped_error: assert property (unmapped |-> pslverr) else $error("unmapped access without error");
    a_unmapped_zero: assert property (unmapped && !pwrite |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_mapped_clean: assert property (psel && penable && paddr[1:0] == 2'h0 && paddr <= 8'h10 |-> !pslverr)
        else $error("error on mapped offset");
    a_error_in_access: assert property (pslverr |-> psel && penable) else $error("error outside access phase");
    a_low_mask_delay: assert property (clock_gate ##1 low_byte_mask && clock_gate |-> ##2 !dq_oe[0])
        else $error("low byte still driven after mask");
    a_high_mask_delay: assert property (clock_gate ##1 high_byte_mask && clock_gate |-> ##2 !dq_oe[1])
        else $error("high byte still driven after mask");
    a_read_latency: assert property (read_taken |-> if (lat3_reg) ##2 dq_oe == 2'h3 else ##1 dq_oe == 2'h3)
        else $error("read data not driven at latency");
endmodule : sdram_command_checker

bind sdram_command_interface sdram_command_checker u_checker (.*);

//--- verification/sdram_command_interface_test.sv
`timescale 1ns/1ps
module sdram_command_interface_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        clock_gate, select_n, row_strobe_n, column_strobe_n, write_strobe_n;
    logic        low_byte_mask, high_byte_mask;
    logic [1:0]  bank_select_pair, dq_oe;
    logic [7:0]  paddr;
    logic [11:0] address;
    logic [15:0] dq_in, dq_out;
    logic [31:0] pwdata, prdata, r;
    int          n_mismatch = 0;
    int          checks_done = 0;
    // {offset, error, data} after reset
    logic [40:0] rows [6] = '{{8'h00, 33'h0}, {8'h04, 33'h0}, {8'h08, 33'h0}, {8'h0C, 33'h1}, {8'h10, 33'h0},
                             {8'h14, 33'h1_0000_0000}};
    logic [15:0] burst [4] = '{16'h2222, 16'h2313, 16'h2020, 16'h1121};
    sdram_command_interface DUT (.*);
    mem_ctrl_model ctrl (.*);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        apb(1'b0, a, 32'h0);
        chk({e, r}, x);
    endtask : rd
    task automatic cmd(input logic [3:0] p, input logic [11:0] a, input logic [1:0] b, input logic g);
        ctrl.drive(p, a, b, g, 2'h0, 16'h0000);
        ctrl.idle_cmd(g);
    endtask : cmd
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        stop_test;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) rd(rows[i][40:33], rows[i][32:0]);
        ctrl.power_up(12'h032);
        rd(8'h00, 33'h032);
        rd(8'h08, 33'h008);
        apb(1'b1, 8'h00, 32'h0FFF);
        apb(1'b1, 8'h0C, 32'h0005);
        rd(8'h00, 33'h032);
        rd(8'h0C, 33'h005);
        cmd(4'hB, 12'h123, 2'h1, 1'b1);
        cmd(4'h3, 12'hABC, 2'h2, 1'b1);
        rd(8'h10, 33'hABC);
        rd(8'h04, 33'h104);
        // second pass masks one byte of beats one and three
        for (int k = 0; k < 2; k++)
            for (int b = 0; b < 4; b++)
                ctrl.drive(b == 0 ? 4'h4 : 4'h7, 12'h000, 2'h2, 1'b1, 2'(k * (b == 1 ? 2 : b == 3 ? 1 : 0)),
                           {2{4'(k + 1), 4'(b)}});
        cmd(4'h5, 12'h402, 2'h2, 1'b1);
        repeat (2) @(posedge pclk);
        for (int b = 0; b < 4; b++) begin
            #1 chk({dq_oe, dq_out}, {2'h3, burst[b]});
            @(posedge pclk);
        end
        rd(8'h04, 33'h100);
        // high byte masked one edge after the read blanks only that byte of the first beat
        cmd(4'h3, 12'hABC, 2'h2, 1'b1);
        ctrl.drive(4'h5, 12'h402, 2'h2, 1'b1, 2'h0, 16'h0000);
        ctrl.drive(4'h7, 12'h000, 2'h2, 1'b1, 2'h2, 16'h0000);
        ctrl.idle_cmd(1'b1);
        @(posedge pclk);
        #1 chk({dq_oe, dq_out}, {2'h1, burst[0]});
        cmd(4'h3, 12'h001, 2'h0, 1'b1);
        cmd(4'h3, 12'h002, 2'h1, 1'b1);
        cmd(4'h2, 12'h000, 2'h0, 1'b1);
        rd(8'h04, 33'h102);
        cmd(4'h2, 12'h400, 2'h3, 1'b1);
        rd(8'h04, 33'h100);
        cmd(4'h1, 12'h000, 2'h0, 1'b1);
        rd(8'h08, 33'h009);
        cmd(4'h7, 12'h000, 2'h0, 1'b0);
        cmd(4'h3, 12'h000, 2'h0, 1'b0);
        rd(8'h04, 33'h140);
        ctrl.idle_cmd(1'b1);
        rd(8'h04, 33'h100);
        cmd(4'h1, 12'h000, 2'h0, 1'b0);
        rd(8'h04, 33'h180);
        // long enough for one internal refresh tick, short of a second
        repeat (400) @(posedge pclk);
        rd(8'h08, 33'h00A);
        ctrl.idle_cmd(1'b1);
        repeat (3) ctrl.idle_cmd(1'b1);
        rd(8'h04, 33'h100);
        stop_test;
    end
endmodule : sdram_command_interface_test
